// ---- emu_mode_pkg.sv ----
// constants shared by the emulation-mode control block
// assumes a 32-bit core with one clock; flags word bit positions as in the core
package emu_mode_pkg;
   // flags word layout
   localparam int VM_BIT = 17;
   localparam int NT_BIT = 14;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
   // privilege forced while emulating
   localparam logic [1:0] EMU_PRIV = 2'h3;
   // emulation address width and reachable limit (just under 1 MByte plus 64 KBytes)
   localparam int EMU_ADDR_W = 20;
   localparam int LIN_ADDR_W = 32;
   localparam logic [31:0] EMU_ADDR_LIMIT = 32'h0010_FFEF;
   // the legacy segment base is selector times sixteen
   localparam int SEG_SHIFT = 4;
   // register-bus map
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CPL = 4'h8;
   typedef enum logic [1:0] {
      SEG_IDLE,
      SEG_LOAD
   } seg_state_e;
endpackage

// ---- emu_mode_ctrl.sv ----
// mode-control logic for the legacy 16-bit emulation mode of the core
// assumes sequencer events are one-cycle pulses, synchronous to clk, one at a time
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps

// Function
// RULE1 - mode follows virtual_machine_flag
// RULE2 - flag set only by switch or return
// RULE3 - direct flag writes keep the flag
// RULE4 - flag steers segment loads and decoding
// RULE5 - 16-bit task_state_segment clears the flag
// RULE6 - switch into flagged task enters mode
// RULE7 - interrupt return with flagged image enters
// RULE8 - nested return to emulation task enters
// RULE9 - flag updated before segment loads
// RULE10 - privilege level three while emulating
// RULE11 - 20-bit addresses zero-extended to 32
// RULE12 - addresses stay below 1 MByte plus 64K
// RULE13 - switch to protected task clears flag
// RULE14 - interrupt service leaves emulation mode
// RULE15 - switch reloads whole flags word
// RULE16 - flag cleared by reset
module emu_mode_ctrl
   import emu_mode_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   // task switch: new flags image and its format
   input wire logic task_switch,
   input wire logic tss_is_32,
   input wire logic [31:0] tss_flags,
   // interrupt return: popped image, and whether the nested target task is in emulation mode
   input wire logic interrupt_return_instruction_exec,
   input wire logic [31:0] stack_flags,
   input wire logic nested_target_emu,
   // interrupt or exception service
   input wire logic intr_service,
   // direct live write (flag pop instruction and the like)
   input wire logic flags_write,
   input wire logic [31:0] flags_wdata,
   // segment load request from the sequencer
   input wire logic seg_load_req,
   input wire logic [15:0] seg_value,
   // 20-bit emulation address to extend
   input wire logic [19:0] emu_addr,
   input wire logic [1:0] prot_cpl,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // results
   output logic [31:0] status_flags_word,
   output logic emu_mode,
   output logic [1:0] current_privilege_level,
   output logic [31:0] linear_addr,
   output logic addr_in_range,
   output logic seg_done,
   output logic [31:0] seg_base,
   output logic seg_legacy,
   output logic decode_legacy
);

   // ************************************************************
   // flag update
   // ************************************************************
   logic [31:0] flags_r, flags_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   function automatic logic [31:0] keep_vm(input logic [31:0] nv, input logic [31:0] old);
      logic [31:0] r;
      r = nv;
      r[VM_BIT] = old[VM_BIT];
      return r;
   endfunction

   always_comb begin
      flags_nxt = flags_r;
      if (task_switch) begin
         // RULE15 whole word reload
         if (tss_is_32) begin
            // RULE6 RULE13 flag from image
            flags_nxt = tss_flags;
         end else begin
            // RULE5 upper half absent
            flags_nxt = {16'h0000, tss_flags[15:0]};
         end
      end else if (interrupt_return_instruction_exec) begin
         // RULE8 nested return target
         if (flags_r[NT_BIT]) begin
            flags_nxt = tss_flags;
            flags_nxt[VM_BIT] = nested_target_emu;
         end else begin
            // RULE7 popped image
            flags_nxt = stack_flags;
         end
      end else if (intr_service) begin
         // RULE14 leave on service
         flags_nxt[VM_BIT] = 1'b0;
      end else if (flags_write) begin
         // RULE3 RULE2 direct write keeps flag
         flags_nxt = keep_vm(flags_wdata, flags_r);
      end else if (reg_wr && reg_addr == ADDR_FLAGS) begin
         // RULE3 software port keeps flag
         flags_nxt = keep_vm(reg_wdata, flags_r);
      end
   end

   // RULE16 reset value clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // ************************************************************
   // segment load sequencing
   // ************************************************************
   seg_state_e seg_state_r, seg_state_nxt;
   logic [15:0] seg_val_r, seg_val_nxt;
   logic [31:0] seg_base_r, seg_base_nxt;
   logic seg_legacy_r, seg_legacy_nxt;
   logic seg_done_r, seg_done_nxt;

   // RULE9 load waits one cycle so the new flag is in place
   always_comb begin
      seg_state_nxt = seg_state_r;
      seg_val_nxt = seg_val_r;
      seg_base_nxt = seg_base_r;
      seg_legacy_nxt = seg_legacy_r;
      seg_done_nxt = 1'b0;
      unique case (seg_state_r)
         SEG_IDLE: begin
            if (seg_load_req) begin
               seg_val_nxt = seg_value;
               seg_state_nxt = SEG_LOAD;
            end
         end
         SEG_LOAD: begin
            // RULE4 legacy translation chosen by flag
            seg_legacy_nxt = flags_r[VM_BIT];
            if (flags_r[VM_BIT]) begin
               seg_base_nxt = {12'h000, seg_val_r, 4'h0};
            end else begin
               seg_base_nxt = 32'h0000_0000;
            end
            seg_done_nxt = 1'b1;
            seg_state_nxt = SEG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seg_state_r <= SEG_IDLE;
         seg_val_r <= 16'h0000;
         seg_base_r <= 32'h0000_0000;
         seg_legacy_r <= 1'b0;
         seg_done_r <= 1'b0;
      end else begin
         seg_state_r <= seg_state_nxt;
         seg_val_r <= seg_val_nxt;
         seg_base_r <= seg_base_nxt;
         seg_legacy_r <= seg_legacy_nxt;
         seg_done_r <= seg_done_nxt;
      end
   end

   // ************************************************************
   // mode outputs
   // ************************************************************
   // RULE1 mode is the flag
   assign emu_mode = flags_r[VM_BIT];
   assign status_flags_word = flags_r;
   // RULE4 decoder sees the flag
   assign decode_legacy = flags_r[VM_BIT];
   // RULE10 forced user privilege
   assign current_privilege_level = flags_r[VM_BIT] ? EMU_PRIV : prot_cpl;
   // RULE11 zero extension before paging
   assign linear_addr = flags_r[VM_BIT] ? {12'h000, emu_addr} : 32'h0000_0000;
   // RULE12 reach is bounded by the 20-bit source alone, checked against EMU_ADDR_LIMIT
   assign addr_in_range = linear_addr <= EMU_ADDR_LIMIT;
   assign seg_done = seg_done_r;
   assign seg_base = seg_base_r;
   assign seg_legacy = seg_legacy_r;

   // ************************************************************
   // register read port
   // ************************************************************
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_FLAGS: rdata_nxt = flags_r;
            ADDR_STATUS: rdata_nxt = {30'h0, seg_legacy_r, flags_r[VM_BIT]};
            ADDR_CPL: rdata_nxt = {30'h0, current_privilege_level};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   // ************************************************************
   // checks
   // ************************************************************
   a_reset_clear: assert property (@(posedge clk) $rose(rst_n) |-> !emu_mode) // RULE16
      else $error("flag not clear after reset");
   a_mode_follow: assert property (@(posedge clk) disable iff (!rst_n)
      emu_mode == status_flags_word[VM_BIT]) // RULE1
      else $error("mode differs from flag");
   a_set_cause: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(emu_mode) |-> $past(task_switch) || $past(interrupt_return_instruction_exec)) // RULE2
      else $error("flag set without switch or return");
   a_pop_keeps: assert property (@(posedge clk) disable iff (!rst_n)
      flags_write && !task_switch && !interrupt_return_instruction_exec && !intr_service
      |=> $stable(emu_mode)) // RULE3
      else $error("direct write changed flag");
   a_narrow_clear: assert property (@(posedge clk) disable iff (!rst_n)
      task_switch && !tss_is_32 |=> !emu_mode) // RULE5
      else $error("16-bit switch left flag set");
   a_switch_enter: assert property (@(posedge clk) disable iff (!rst_n)
      task_switch && tss_is_32 |=> emu_mode == $past(tss_flags[VM_BIT])) // RULE6
      else $error("switch did not take flag image");
   a_interrupt_return_instruction_enter: assert property (@(posedge clk) disable iff (!rst_n)
      interrupt_return_instruction_exec && !task_switch && !status_flags_word[NT_BIT]
      |=> emu_mode == $past(stack_flags[VM_BIT])) // RULE7
      else $error("return did not take popped flag");
   a_nested_enter: assert property (@(posedge clk) disable iff (!rst_n)
      interrupt_return_instruction_exec && !task_switch && status_flags_word[NT_BIT]
      |=> emu_mode == $past(nested_target_emu)) // RULE8
      else $error("nested return wrong mode");
   a_seg_order: assert property (@(posedge clk) disable iff (!rst_n)
      seg_load_req && seg_state_r == SEG_IDLE ##1 1'b1 |=> seg_done
      && seg_legacy == $past(emu_mode)) // RULE9
      else $error("segment load used stale flag");
   a_priv_three: assert property (@(posedge clk) disable iff (!rst_n)
      emu_mode |-> current_privilege_level == EMU_PRIV) // RULE10
      else $error("privilege not three in mode");
   a_addr_extend: assert property (@(posedge clk) disable iff (!rst_n)
      emu_mode |-> linear_addr[31:EMU_ADDR_W] == 12'h000 && addr_in_range) // RULE11
      else $error("address not zero-extended");
   a_intr_leave: assert property (@(posedge clk) disable iff (!rst_n)
      intr_service && !task_switch && !interrupt_return_instruction_exec |=> !emu_mode) // RULE14
      else $error("service left flag set");

   // ************************************************************
   // checks on flag images and outputs
   // ************************************************************
   // the two reload checks watch the full word as well as the mode bit, so a loader
   // that got only the mode bit right would still be caught

   a_whole_reload: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
      task_switch && tss_is_32 |=> status_flags_word == $past(tss_flags))
      else $error("switch did not reload whole word");

   a_narrow_word: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
      task_switch && !tss_is_32 |=> status_flags_word[31:16] == 16'h0000
      && status_flags_word[15:0] == $past(tss_flags[15:0]))
      else $error("16-bit switch loaded upper half");

   a_switch_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      task_switch && tss_is_32 && !tss_flags[VM_BIT] |=> !emu_mode)
      else $error("switch to protected task kept flag");

   a_port_keeps: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      reg_wr && reg_addr == ADDR_FLAGS && !task_switch && !interrupt_return_instruction_exec && !intr_service
      && !flags_write |=> $stable(emu_mode))
      else $error("port write changed flag");

   a_decode_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      decode_legacy == emu_mode)
      else $error("decoder mode differs from flag");

   // outside the mode the core's own privilege and no legacy address apply
   a_prot_cpl: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
      !emu_mode |-> current_privilege_level == prot_cpl)
      else $error("privilege forced outside mode");

   a_prot_addr: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      !emu_mode |-> linear_addr == 32'h0000_0000)
      else $error("legacy address outside mode");

   a_addr_reach: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      emu_mode |-> linear_addr <= EMU_ADDR_LIMIT)
      else $error("address beyond emulation reach");

   a_seg_legacy_base: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      seg_done && seg_legacy |-> seg_base[3:0] == 4'h0 && seg_base[31:20] == 12'h000)
      else $error("legacy base not selector times sixteen");

   a_seg_prot_base: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      seg_done && !seg_legacy |-> seg_base == 32'h0000_0000)
      else $error("protected load used legacy base");

   a_seg_latency: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
      seg_done |-> $past(seg_state_r == SEG_LOAD))
      else $error("segment done without load cycle");

   a_seg_pulse: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
      seg_done |=> !seg_done)
      else $error("segment done longer than one cycle");
endmodule

// ---- tb_top.sv ----
// self-checking bench for the emulation-mode control block
// assumes emu_mode_pkg and emu_mode_ctrl are compiled first; one 25 MHz clock
`timescale 1ns/10ps

module tb_top;
   import emu_mode_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0;
   logic task_switch = 1'b0, tss_is_32 = 1'b0, interrupt_return_instruction_exec = 1'b0, nested_target_emu = 1'b0;
   logic intr_service = 1'b0, flags_write = 1'b0, seg_load_req = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [31:0] tss_flags = '0, stack_flags = '0, flags_wdata = '0, reg_wdata = '0;
   logic [15:0] seg_value = '0;
   logic [19:0] emu_addr = '0;
   logic [1:0] prot_cpl = '0;
   logic [3:0] reg_addr = '0;
   logic [31:0] reg_rdata, status_flags_word, linear_addr, seg_base;
   logic emu_mode, addr_in_range, seg_done, seg_legacy, decode_legacy;
   logic [1:0] current_privilege_level;
   int err_count = 0, cmp_count = 0;

   emu_mode_ctrl emu_mode_ctrl_inst (.clk(clk), .rst_n(rst_n), .task_switch(task_switch),
      .tss_is_32(tss_is_32), .tss_flags(tss_flags), .interrupt_return_instruction_exec(interrupt_return_instruction_exec),
      .stack_flags(stack_flags), .nested_target_emu(nested_target_emu),
      .intr_service(intr_service), .flags_write(flags_write), .flags_wdata(flags_wdata),
      .seg_load_req(seg_load_req), .seg_value(seg_value), .emu_addr(emu_addr),
      .prot_cpl(prot_cpl), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_flags_word(status_flags_word),
      .emu_mode(emu_mode), .current_privilege_level(current_privilege_level),
      .linear_addr(linear_addr), .addr_in_range(addr_in_range), .seg_done(seg_done),
      .seg_base(seg_base), .seg_legacy(seg_legacy), .decode_legacy(decode_legacy));

   initial begin
      forever #20 clk = ~clk;
   end

   // ***********************************************
   // shared drivers and comparison
   // ***********************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // each driver holds its pulse for one edge, then samples after that edge settles
   task automatic tsw(input logic is32, input logic [31:0] f);
      @(posedge clk);
      task_switch <= 1'b1;
      tss_is_32 <= is32;
      tss_flags <= f;
      @(posedge clk);
      task_switch <= 1'b0;
      #1;
   endtask

   task automatic interrupt_return_instruction(input logic [31:0] sf, input logic nte);
      @(posedge clk);
      interrupt_return_instruction_exec <= 1'b1;
      stack_flags <= sf;
      nested_target_emu <= nte;
      @(posedge clk);
      interrupt_return_instruction_exec <= 1'b0;
      #1;
   endtask

   task automatic fwrite(input logic [31:0] d);
      @(posedge clk);
      flags_write <= 1'b1;
      flags_wdata <= d;
      @(posedge clk);
      flags_write <= 1'b0;
      #1;
   endtask

   task automatic reg_access(input logic wr, input logic [3:0] a, input logic [31:0] d,
                             output logic [31:0] q);
      @(posedge clk);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_direct_writes;
      logic [31:0] q;
      check("reset flags", status_flags_word, 32'h0000_0002);
      fwrite(32'h0002_0246);
      check("pop keeps flag", status_flags_word, 32'h0000_0246);
      reg_access(1'b1, ADDR_FLAGS, 32'h0002_0013, q);
      reg_access(1'b0, ADDR_FLAGS, '0, q);
      check("port write keeps flag", q, 32'h0000_0013);
   endtask

   task automatic t_enter_by_switch;
      logic [31:0] q;
      prot_cpl <= 2'h1;
      emu_addr <= 20'hFFFFF;
      tsw(1'b1, 32'h0002_3202);
      check("switch whole word", status_flags_word, 32'h0002_3202);
      check("switch enters", {emu_mode, decode_legacy}, 32'h3);
      check("cpl three", current_privilege_level, 32'h3);
      check("zero extend", linear_addr, 32'h000F_FFFF);
      check("in range", addr_in_range, 32'h1);
      fwrite(32'h0000_0002);
      check("pop keeps set flag", status_flags_word, 32'h0002_0002);
      reg_access(1'b0, ADDR_STATUS, '0, q);
      check("status reg", q, 32'h0000_0001);
      reg_access(1'b0, ADDR_CPL, '0, q);
      check("cpl reg", q, 32'h0000_0003);
      reg_access(1'b0, 4'hC, '0, q);
      check("unmapped reads zero", q, 32'h0);
   endtask

   task automatic t_leave_and_return;
      tsw(1'b0, 32'h0002_0246);
      check("16-bit image", status_flags_word, 32'h0000_0246);
      check("protected cpl", current_privilege_level, 32'h1);
      check("no legacy address", linear_addr, 32'h0);
      interrupt_return_instruction(32'h0002_0002, 1'b0);
      check("interrupt_return_instruction enters", emu_mode, 32'h1);
      @(posedge clk);
      intr_service <= 1'b1;
      @(posedge clk);
      intr_service <= 1'b0;
      #1;
      check("service leaves", emu_mode, 32'h0);
      fwrite(32'h0000_4002);
      tss_flags <= 32'h0000_0202;
      interrupt_return_instruction(32'h0000_0002, 1'b1);
      check("nested return", status_flags_word, 32'h0002_0202);
   endtask

   // switch and segment load share an edge: the new flag must steer the load
   task automatic seg_chk(input logic [31:0] f, input logic [15:0] sel, input logic [31:0] base,
                          input logic leg);
      int n;
      @(posedge clk);
      task_switch <= 1'b1;
      tss_is_32 <= 1'b1;
      tss_flags <= f;
      seg_load_req <= 1'b1;
      seg_value <= sel;
      @(posedge clk);
      task_switch <= 1'b0;
      seg_load_req <= 1'b0;
      #1;
      n = 0;
      while (seg_done !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("seg done", seg_done, 32'h1);
      check("seg latency", n, 32'h1);
      check("seg base", seg_base, base);
      check("seg legacy", seg_legacy, leg);
   endtask

   // ***********************************************
   // run control
   // ***********************************************
   task automatic test_done;
      $display("TB: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_direct_writes();
      t_enter_by_switch();
      t_leave_and_return();
      seg_chk(32'h0002_0002, 16'h1234, 32'h0001_2340, 1'b1);
      seg_chk(32'h0000_0002, 16'h1234, 32'h0, 1'b0);
      test_done();
   end

   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      test_done();
   end
endmodule
